// File: refmute_regs.sv
// reference status, status pin driver and mute level register bank
// Function
// - bits 7:6 show secondary input rise/fall valid, read only, reset 0
// - bits 5:4 show primary input rise/fall valid, read only, reset 0
// - input status bits 3:0 reserved with no function
// - bit 5 set limits current spikes on status pin one
// - bit 4 set limits current spikes on status pin zero
// - bit 1 set makes status pin one open drain, else push-pull
// - bit 0 set makes status pin zero open drain, else push-pull
// - pin control 7:6 reserved; 3:2 reserved read-write, reset 0
// - mute levels of channel 3 at 7:6 and channel 2 at 5:4, reset 1
// - differential mute codes: bypass, common mode, high, rail/ground
// - single-ended mute codes: bypass, n low, p low, both low
// - level picks driver state only; channel mute enable decides muting
// - channel 1 level at bits 3:2, channel 0 at 1:0, reset 1
`timescale 1ns/1ns
`include "refmute_consts.svh"

module refmute_regs
    import refmute_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        SECOND_INPUT_RISE_OK,
    input  wire logic        SECOND_INPUT_FALL_OK,
    input  wire logic        FIRST_INPUT_RISE_OK,
    input  wire logic        FIRST_INPUT_FALL_OK,
    input  wire logic        STATUS_PIN_ZERO_SRC,
    input  wire logic        STATUS_PIN_ONE_SRC,
    output logic             STATUS_PIN_ZERO_O,
    output logic             STATUS_PIN_ZERO_OE,
    output logic             STATUS_PIN_ONE_O,
    output logic             STATUS_PIN_ONE_OE,
    output logic             STATUS_PIN0_CURRENT_LIMIT,
    output logic             STATUS_PIN1_CURRENT_LIMIT,
    input  wire logic [3:0]  CHAN_MUTE_ENABLE,
    input  wire logic [3:0]  CHAN_DIFF_MODE,
    output logic [11:0]      CHAN_P_DRIVE,
    output logic [11:0]      CHAN_N_DRIVE
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    // one-hot hit: [0] edge status, [1] pin control, [2] mute level
    function automatic logic [2:0] reg_hit(input logic [7:0] addr);
        reg_hit = {addr == {`IDX_MUTE_LVL, 2'b00},
                   addr == {`IDX_PIN_CTL, 2'b00},
                   addr == {`IDX_EDGE_STATUS, 2'b00}};
    endfunction : reg_hit

    // positive node state for a mute code
    function automatic node_drive_t mute_p(input mute_code_t code,
                                           input logic diff,
                                           input logic en);
        mute_p = DRV_NORMAL;
        if (en) begin
            case (code)
                `MUTE_CODE_LEVEL1: mute_p = diff ? DRV_VCM : DRV_NORMAL;
                `MUTE_CODE_LEVEL2: mute_p = diff ? DRV_HIGH : DRV_LOW;
                `MUTE_CODE_LEVEL3: mute_p = diff ? DRV_RAIL : DRV_LOW;
                default:           mute_p = DRV_NORMAL;
            endcase
        end
    endfunction : mute_p

    // negative node state for a mute code
    function automatic node_drive_t mute_n(input mute_code_t code,
                                           input logic diff,
                                           input logic en);
        mute_n = DRV_NORMAL;
        if (en) begin
            case (code)
                `MUTE_CODE_LEVEL1: mute_n = diff ? DRV_VCM : DRV_LOW;
                `MUTE_CODE_LEVEL2: mute_n = diff ? DRV_LOW : DRV_NORMAL;
                `MUTE_CODE_LEVEL3: mute_n = DRV_LOW;
                default:           mute_n = DRV_NORMAL;
            endcase
        end
    endfunction : mute_n

    // ************************************************************
    // edge indicator synchronisers
    // ************************************************************
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] ind_q;
    logic [3:0] ind_d;
    wire  [3:0] ind_pins = {SECOND_INPUT_RISE_OK, SECOND_INPUT_FALL_OK,
                            FIRST_INPUT_RISE_OK, FIRST_INPUT_FALL_OK};
    wire  [3:0] ind_agree = ~(sync2_q ^ sync3_q);

    assign ind_d = (sync3_q & ind_agree) | (ind_q & ~ind_agree);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= `RST_EDGE_IND;
            sync2_q <= `RST_EDGE_IND;
            sync3_q <= `RST_EDGE_IND;
            ind_q   <= `RST_EDGE_IND;
        end else begin
            sync1_q <= ind_pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            ind_q   <= ind_d;
        end
    end

    // ************************************************************
    // write channel
    // ************************************************************
    logic [7:0] aw_addr_q;
    logic       aw_full_q;
    logic [7:0] w_data_q;
    logic       w_lane0_q;
    logic       w_full_q;
    logic       bvalid_q;
    logic [1:0] bresp_q;
    logic [5:0] pin_ctl_q;
    logic [7:0] mute_q;

    wire       aw_take  = S_AXI_AWVALID & S_AXI_AWREADY;
    wire       w_take   = S_AXI_WVALID & S_AXI_WREADY;
    wire       do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire [2:0] w_hit    = reg_hit(aw_addr_q);
    wire       w_ok     = |w_hit;
    // edge status register is not a write target
    wire       wr_pin   = do_write & w_lane0_q & w_hit[1];
    wire       wr_mute  = do_write & w_lane0_q & w_hit[2];

    assign S_AXI_AWREADY = ~aw_full_q & ~bvalid_q;
    assign S_AXI_WREADY  = ~w_full_q & ~bvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_addr_q <= 8'h00;
            aw_full_q <= 1'b0;
        end else if (aw_take) begin
            aw_addr_q <= S_AXI_AWADDR;
            aw_full_q <= 1'b1;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            w_full_q  <= 1'b0;
        end else if (w_take) begin
            w_data_q  <= S_AXI_WDATA[7:0];
            w_lane0_q <= S_AXI_WSTRB[0];
            w_full_q  <= 1'b1;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // pin control storage
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_ctl_q <= `RST_PIN_CTL;
        end else if (wr_pin) begin
            pin_ctl_q <= w_data_q[5:0];
        end
    end

    // mute levels, channel ch at bits 2ch+1:2ch
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mute_q <= `RST_MUTE_LVL;
        end else if (wr_mute) begin
            mute_q <= w_data_q;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    wire  [2:0]  r_hit  = reg_hit(S_AXI_ARADDR);
    wire         ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    wire  [7:0]  r_byte = ({8{r_hit[0]}} & {ind_q, 4'h0})
                        | ({8{r_hit[1]}} & {2'b00, pin_ctl_q})
                        | ({8{r_hit[2]}} & mute_q);

    assign S_AXI_ARREADY = ~rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, r_byte};
            rresp_q  <= (|r_hit) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // status pin drivers
    // ************************************************************
    logic [1:0] pin_o_q;
    logic [1:0] pin_oe_q;
    wire  [1:0] pin_src = {STATUS_PIN_ONE_SRC, STATUS_PIN_ZERO_SRC};
    wire  [1:0] pin_od  = {pin_ctl_q[`POS_PIN1_OD], pin_ctl_q[`POS_PIN0_OD]};
    // open drain pulls low only, else push-pull
    wire  [1:0] pin_o_d  = pin_src & ~pin_od;
    wire  [1:0] pin_oe_d = ~pin_od | ~pin_src;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_o_q  <= 2'b00;
            pin_oe_q <= 2'b00;
        end else begin
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign STATUS_PIN_ZERO_O  = pin_o_q[0];
    assign STATUS_PIN_ZERO_OE = pin_oe_q[0];
    assign STATUS_PIN_ONE_O   = pin_o_q[1];
    assign STATUS_PIN_ONE_OE  = pin_oe_q[1];
    assign STATUS_PIN1_CURRENT_LIMIT = pin_ctl_q[`POS_PIN1_LIMIT];
    assign STATUS_PIN0_CURRENT_LIMIT = pin_ctl_q[`POS_PIN0_LIMIT];

    // ************************************************************
    // channel mute drive
    // ************************************************************
    logic [11:0] p_drive_d;
    logic [11:0] n_drive_d;
    logic [11:0] p_drive_q;
    logic [11:0] n_drive_q;

    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        assign p_drive_d[ch*3 +: 3] = mute_p(mute_q[ch*2 +: 2],
                                             CHAN_DIFF_MODE[ch],
                                             CHAN_MUTE_ENABLE[ch]);
        assign n_drive_d[ch*3 +: 3] = mute_n(mute_q[ch*2 +: 2],
                                             CHAN_DIFF_MODE[ch],
                                             CHAN_MUTE_ENABLE[ch]);
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            p_drive_q <= 12'h000;
            n_drive_q <= 12'h000;
        end else begin
            p_drive_q <= p_drive_d;
            n_drive_q <= n_drive_d;
        end
    end

    assign CHAN_P_DRIVE = p_drive_q;
    assign CHAN_N_DRIVE = n_drive_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_edge_settle: assert property (
        ((ind_q ^ $past(ind_q)) & ~$past(ind_agree)) == 4'h0)
        else $error("edge indicator moved before pins settled");
    a_edge_read: assert property (
        ar_take && r_hit[0] |=> S_AXI_RDATA[7:4] == $past(ind_q)
                                && S_AXI_RDATA[3:0] == 4'h0)
        else $error("edge status read mismatch");
    a_rsvd_upper: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_limit_write: assert property (
        wr_pin |=> STATUS_PIN1_CURRENT_LIMIT == $past(w_data_q[5])
                   && STATUS_PIN0_CURRENT_LIMIT == $past(w_data_q[4]))
        else $error("current limit not taken from write");
    a_od_low_only: assert property (
        $past(RST_N && pin_ctl_q[`POS_PIN0_OD]) |-> !STATUS_PIN_ZERO_O
            && STATUS_PIN_ZERO_OE == !$past(STATUS_PIN_ZERO_SRC))
        else $error("open drain pin zero drove high");
    a_push_pull: assert property (
        $past(RST_N && !pin_ctl_q[`POS_PIN1_OD]) |-> STATUS_PIN_ONE_OE
            && STATUS_PIN_ONE_O == $past(STATUS_PIN_ONE_SRC))
        else $error("push-pull pin one wrong");
    a_ro_ignored: assert property (
        do_write && w_hit[0] |=> $stable(pin_ctl_q) && $stable(mute_q))
        else $error("write to read-only register changed state");
    a_mute_gate: assert property (
        $past(RST_N && !CHAN_MUTE_ENABLE[0])
        |-> CHAN_P_DRIVE[2:0] == DRV_NORMAL && CHAN_N_DRIVE[2:0] == DRV_NORMAL)
        else $error("unmuted channel not normal");
    a_mute_diff3: assert property (
        $past(RST_N && CHAN_MUTE_ENABLE[3] && CHAN_DIFF_MODE[3]
              && mute_q[7:6] == `MUTE_CODE_LEVEL3)
        |-> CHAN_P_DRIVE[11:9] == DRV_RAIL && CHAN_N_DRIVE[11:9] == DRV_LOW)
        else $error("differential code 3 wrong");
    a_mute_se1: assert property (
        $past(RST_N && CHAN_MUTE_ENABLE[2] && !CHAN_DIFF_MODE[2]
              && mute_q[5:4] == `MUTE_CODE_LEVEL1)
        |-> CHAN_P_DRIVE[8:6] == DRV_NORMAL && CHAN_N_DRIVE[8:6] == DRV_LOW)
        else $error("single-ended code 1 wrong");
    a_mute_store: assert property (
        wr_mute |=> mute_q == $past(w_data_q))
        else $error("mute level write lost");
    a_pin_rsvd: assert property (
        ar_take && r_hit[1] |=> S_AXI_RDATA[7:6] == 2'b00
                                && S_AXI_RDATA[3:2] == $past(pin_ctl_q[3:2]))
        else $error("pin control reserved bits wrong");

    c_mute_write: cover property (wr_mute);
    c_edge_read: cover property (ar_take && r_hit[0]);
    c_bad_read: cover property (ar_take && !(|r_hit));
    c_both_same: cover property (aw_take && w_take);

endmodule : refmute_regs

// File: refmute_consts.svh
// register offsets, field positions and reset values of the bank
`ifndef REFMUTE_CONSTS_SVH
`define REFMUTE_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_EDGE_STATUS      6'h12
`define IDX_PIN_CTL          6'h13
`define IDX_MUTE_LVL         6'h14

// input edge status fields
`define POS_SEC_RISE         7
`define POS_SEC_FALL         6
`define POS_PRI_RISE         5
`define POS_PRI_FALL         4
`define RST_EDGE_IND         4'h0

// status pin control fields
`define POS_PIN1_LIMIT       5
`define POS_PIN0_LIMIT       4
`define POS_PIN_RSVD_HI      3
`define POS_PIN_RSVD_LO      2
`define POS_PIN1_OD          1
`define POS_PIN0_OD          0
`define RST_PIN_CTL          6'h00

// mute level fields, two bits per channel at 2*ch
`define MUTE_FIELD_W         2
`define RST_MUTE_LVL         8'h55
`define MUTE_CODE_BYPASS     2'h0
`define MUTE_CODE_LEVEL1     2'h1
`define MUTE_CODE_LEVEL2     2'h2
`define MUTE_CODE_LEVEL3     2'h3

// bus answers
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// File: refmute_pkg.sv
// types shared by the reference status and mute level bank
package refmute_pkg;

    // state applied to one output node of a channel driver
    typedef enum logic [2:0] {
        DRV_NORMAL = 3'h0,
        DRV_LOW    = 3'h1,
        DRV_HIGH   = 3'h2,
        DRV_VCM    = 3'h3,
        DRV_RAIL   = 3'h4
    } node_drive_t;

    typedef logic [1:0] mute_code_t;

endpackage : refmute_pkg

// File: test_refmute_regs.sv
// self-checking bench for the reference status and mute level bank
`timescale 1ns/1ns
`include "refmute_consts.svh"

module test_refmute_regs
    import refmute_pkg::*;
;
    localparam logic [7:0] A_EDGE = {`IDX_EDGE_STATUS, 2'b00};
    localparam logic [7:0] A_PIN  = {`IDX_PIN_CTL, 2'b00};
    localparam logic [7:0] A_MUTE = {`IDX_MUTE_LVL, 2'b00};

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  wd;
        logic [3:0]  strb;
        logic [1:0]  bexp;
        logic [31:0] mask;
        logic [31:0] rexp;
        logic [1:0]  rrexp;
    } row_t;

    // write, then read back through the mask
    localparam row_t ROWS [6] = '{
        '{A_PIN,  8'hff, 4'h1, `RESP_OKAY, 32'hffffff3f, 32'h3f, `RESP_OKAY},
        '{A_PIN,  8'h00, 4'h1, `RESP_OKAY, 32'hffffff3f, 32'h00, `RESP_OKAY},
        '{A_MUTE, 8'he4, 4'h1, `RESP_OKAY, 32'hffffffff, 32'he4, `RESP_OKAY},
        '{A_MUTE, 8'h1b, 4'h0, `RESP_OKAY, 32'hffffffff, 32'he4, `RESP_OKAY},
        '{A_EDGE, 8'hff, 4'h1, `RESP_OKAY, 32'hfffffff0, 32'h00, `RESP_OKAY},
        '{8'h40,  8'hff, 4'h1, `RESP_SLVERR, 32'hffffffff, 32'h0, `RESP_SLVERR}
    };

    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  edge_ok = 4'h0;
    logic        src0 = 1'b0, src1 = 1'b0;
    logic        pin0_o, pin0_oe, pin1_o, pin1_oe, lim0, lim1;
    logic [3:0]  mute_en = 4'h0;
    logic [3:0]  diff_mode = 4'h0;
    logic [11:0] p_drive, n_drive;
    int          errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  want2;
    logic [5:0]  seen6, want6;

    refmute_regs dut_u (
        .CORE_CLK(core_clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready),
        .SECOND_INPUT_RISE_OK(edge_ok[3]), .SECOND_INPUT_FALL_OK(edge_ok[2]),
        .FIRST_INPUT_RISE_OK(edge_ok[1]), .FIRST_INPUT_FALL_OK(edge_ok[0]),
        .STATUS_PIN_ZERO_SRC(src0), .STATUS_PIN_ONE_SRC(src1),
        .STATUS_PIN_ZERO_O(pin0_o), .STATUS_PIN_ZERO_OE(pin0_oe),
        .STATUS_PIN_ONE_O(pin1_o), .STATUS_PIN_ONE_OE(pin1_oe),
        .STATUS_PIN0_CURRENT_LIMIT(lim0), .STATUS_PIN1_CURRENT_LIMIT(lim1),
        .CHAN_MUTE_ENABLE(mute_en), .CHAN_DIFF_MODE(diff_mode),
        .CHAN_P_DRIVE(p_drive), .CHAN_N_DRIVE(n_drive)
    );

    always #5 core_clk = ~core_clk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        check_count++;
        if (seen !== expd) begin
            errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, expd);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // upper bytes carry junk, which must be ignored
    task automatic bus_write(input logic [7:0] a, input logic [7:0] v,
                             input logic [3:0] s, output logic [1:0] resp);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'ha5c3e1, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] v,
                            output logic [1:0] resp);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : bus_read

    task automatic check_resets();
        logic [31:0] v;
        logic [1:0]  rs;
        bus_read(A_PIN, v, rs);
        check(v & 32'hffffff3f, 32'h0);
        bus_read(A_MUTE, v, rs);
        check(v, 32'(`RST_MUTE_LVL));
        bus_read(A_EDGE, v, rs);
        check(v & 32'hfffffff0, 32'h0);
    endtask : check_resets

    // expected {p, n} drive of one channel
    function automatic logic [5:0] drive_of(input logic [1:0] c,
                                            input logic dm, input logic m);
        if (!m || c == `MUTE_CODE_BYPASS) return {DRV_NORMAL, DRV_NORMAL};
        case ({dm, c})
            3'b101: return {DRV_VCM, DRV_VCM};
            3'b110: return {DRV_HIGH, DRV_LOW};
            3'b111: return {DRV_RAIL, DRV_LOW};
            3'b001: return {DRV_NORMAL, DRV_LOW};
            3'b010: return {DRV_LOW, DRV_NORMAL};
            default: return {DRV_LOW, DRV_LOW};
        endcase
    endfunction : drive_of

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge core_clk);
        check({pin1_oe, pin0_oe, lim1, lim0}, 4'h0);
        rst_n <= 1'b1;
        check_resets();
        foreach (ROWS[i]) begin
            bus_write(ROWS[i].addr, ROWS[i].wd, ROWS[i].strb, r);
            check(r, ROWS[i].bexp);
            bus_read(ROWS[i].addr, d, r);
            check(d & ROWS[i].mask, ROWS[i].rexp);
            check(r, ROWS[i].rrexp);
        end
        for (int v = 0; v < 4; v++) begin
            bus_write(A_PIN, {2'b00, v[1:0], 2'b00, v[1:0]}, 4'h1, r);
            for (int s = 0; s < 2; s++) begin
                @(posedge core_clk);
                src0 <= s[0];
                src1 <= ~s[0];
                repeat (2) @(posedge core_clk);
                check({lim1, lim0}, v[1:0]);
                want2 = v[0] ? {1'b0, ~s[0]} : {s[0], 1'b1};
                check({pin0_o, pin0_oe}, want2);
                want2 = v[1] ? {1'b0, s[0]} : {~s[0], 1'b1};
                check({pin1_o, pin1_oe}, want2);
            end
        end
        for (int k = 0; k < 2; k++) begin
            edge_ok <= k[0] ? 4'h5 : 4'ha;
            repeat (6) @(posedge core_clk);
            bus_write(A_EDGE, 8'hff, 4'h1, r);
            bus_read(A_EDGE, d, r);
            check(d & 32'hfffffff0, k[0] ? 32'h50 : 32'ha0);
        end
        for (int c = 0; c < 4; c++) begin
            bus_write(A_MUTE, {4{c[1:0]}}, 4'h1, r);
            for (int m = 0; m < 2; m++) begin
                @(posedge core_clk);
                diff_mode <= m[0] ? 4'h3 : 4'hc;
                mute_en <= m[0] ? 4'h6 : 4'h9;
                repeat (2) @(posedge core_clk);
                for (int ch = 0; ch < 4; ch++) begin
                    seen6 = {p_drive[3*ch+:3], n_drive[3*ch+:3]};
                    want6 = drive_of(c[1:0], diff_mode[ch], mute_en[ch]);
                    check(seen6, want6);
                end
            end
        end
        bus_write(A_PIN, 8'h33, 4'h1, r);
        @(posedge core_clk);
        edge_ok <= 4'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({pin1_oe, pin0_oe, lim1, lim0}, 4'h0);
        check(p_drive | n_drive, 12'h0);
        rst_n <= 1'b1;
        check_resets();
        give_verdict();
    end

endmodule : test_refmute_regs
